// File: fpe_pkg.sv
// Purpose: shared constants and types of the flash program/erase controller
// Assumes: 32-bit AXI4-Lite register port, 100 MHz clock
// Notes:   one register per aligned word
package fpe_pkg;
    // ---------------------------------------------------------------
    // clock and timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS       = 10;
    localparam int PROG_TIME_NS        = 15000;
    localparam int ERASE_TIME_MS       = 15;
    localparam int PROG_CYCLES         = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ERASE_CYCLES        = (ERASE_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W               = 24;

    // ---------------------------------------------------------------
    // flash geometry
    // ---------------------------------------------------------------
    localparam int FLASH_AW            = 15;
    localparam int PAGE_AW             = 9;
    localparam int PAGE_BYTES          = 512;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // ---------------------------------------------------------------
    // register map and fields
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_KEY     = 8'h00;
    localparam logic [7:0] OFS_CTRL    = 8'h04;
    localparam logic [7:0] OFS_STATUS  = 8'h08;
    localparam logic [7:0] OFS_ADDR    = 8'h0C;
    localparam logic [7:0] OFS_DATA    = 8'h10;
    localparam int CTRL_WE_BIT         = 0;
    localparam int CTRL_EE_BIT         = 1;
    localparam int CTRL_RT_BIT         = 4;
    localparam logic [4:0] CTRL_RST    = 5'h00;
    localparam logic [7:0] KEY_FIRST   = 8'hA5;
    localparam logic [7:0] KEY_SECOND  = 8'hF1;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        KEY_LOCKED = 2'b00,
        KEY_HALF   = 2'b01,
        KEY_OPEN   = 2'b10,
        KEY_DEAD   = 2'b11
    } fpe_key_e;

    typedef struct packed {
        logic                valid;
        logic [FLASH_AW-1:0] addr;
        logic [7:0]          data;
    } fpe_xwr_s;
endpackage

// File: fpe_timer.sv
// Purpose: one-shot operation timer for flash program and erase
// Assumes: load is a one-cycle pulse with a count of at least one
// Notes:   done pulses once when the count runs out
`timescale 1ns/1ps
module fpe_timer
    import fpe_pkg::*;
(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             load,
    input  wire logic [TMR_W-1:0] count,
    output logic                  busy,
    output logic                  done
);
    logic [TMR_W-1:0] cnt_q;
    logic             busy_q;
    logic             done_q;

    wire last = busy_q && (cnt_q == TMR_W'(1));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q  <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= last;
            if (load) begin
                cnt_q  <= count;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                cnt_q  <= cnt_q - TMR_W'(1);
                busy_q <= !last;
            end
        end
    end

    assign busy = busy_q;
    assign done = done_q;
endmodule

// File: fpe_array.sv
// Purpose: program flash storage array
// Assumes: one write per cycle; program mode ands data into the cell
// Notes:   starts erased in simulation
`timescale 1ns/1ps
module fpe_array
    import fpe_pkg::*;
#(
    parameter int AW = FLASH_AW
) (
    input  wire logic          aclk,
    input  wire logic          we,
    input  wire logic          and_mode,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata,
    input  wire logic [AW-1:0] raddr,
    output logic [7:0]         rdata
);
    logic [7:0] mem [0:(1<<AW)-1];

    initial begin
        for (int i = 0; i < (1 << AW); i++) begin
            mem[i] = ERASED_BYTE;
        end
    end

    // program can only clear bits, erase writes ones
    always_ff @(posedge aclk) begin
        if (we) begin
            mem[waddr] <= and_mode ? (mem[waddr] & wdata) : wdata;
        end
    end

    assign rdata = mem[raddr];
endmodule

// File: fpe_ctrl.sv
// Contract
// - programming only clears bits; erase sets them
// - hardware times every operation, no polling
// - stall execution while an operation runs
// - unlock needs 0xA5 then 0xF1, any delay
// - wrong key order or value locks out
// - operation before unlock locks out until reset
// - relock after every program or erase; a debug port program or erase leaves the key state as it is
// - write enable redirects data moves to flash
// - write enable cleared only by software
// - unlocked redirected write programs addressed byte
// - erase sets whole 512-byte page to 0xFF
// - erase enable turns write into page erase
// - debug port programs without any key
//
// Purpose: flash program/erase control with AXI4-Lite registers
// Assumes: debug programming port runs on aclk; erase count >= 512
// Notes:   write response to the data register waits for the operation
`timescale 1ns/1ps
module fpe_ctrl
    import fpe_pkg::*;
#(
    parameter int PROG_COUNT  = PROG_CYCLES,
    parameter int ERASE_COUNT = ERASE_CYCLES
) (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic [2:0]          s_axi_awprot,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic [2:0]          s_axi_arprot,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic                dbg_valid,
    input  wire logic                dbg_erase,
    input  wire logic [FLASH_AW-1:0] dbg_addr,
    input  wire logic [7:0]          dbg_data,
    output logic                     dbg_ack,
    output logic                     core_stall,
    output logic                     flash_read_timing_select,
    output fpe_xwr_s                 xdata_wr
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    fpe_key_e            key_q, key_d;
    logic [4:0]          ctrl_q;
    logic [FLASH_AW-1:0] addr_q;
    logic                aw_have_q, w_have_q, wait_op_q;
    logic [7:0]          awaddr_q, araddr_w;
    logic [31:0]         wdata_q;
    logic [3:0]          wstrb_q;
    logic                awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0]          bresp_q, rresp_q;
    logic [31:0]         rdata_q;
    logic                stall_q, dbg_ack_q;
    fpe_xwr_s            xwr_q;
    logic                erasing_q;
    logic [PAGE_AW:0]    sweep_q;
    logic [FLASH_AW-1:0] op_addr_q;
    logic                op_busy, op_done;
    logic [7:0]          flash_rdata;

    // ---------------------------------------------------------------
    // write channel decode
    // ---------------------------------------------------------------
    wire program_store_write_enable      = ctrl_q[CTRL_WE_BIT];
    wire program_store_erase_enable      = ctrl_q[CTRL_EE_BIT];
    wire aw_take   = s_axi_awvalid && awready_q;
    wire w_take    = s_axi_wvalid && wready_q;
    wire wr_do     = aw_have_q && w_have_q && !bvalid_q && !wait_op_q && !op_busy;
    wire lane0     = wstrb_q[0];
    wire hit_key   = (awaddr_q == OFS_KEY);
    wire hit_ctrl  = (awaddr_q == OFS_CTRL);
    wire hit_stat  = (awaddr_q == OFS_STATUS);
    wire hit_addr  = (awaddr_q == OFS_ADDR);
    wire hit_data  = (awaddr_q == OFS_DATA);
    wire wr_mapped = hit_key || hit_ctrl || hit_stat || hit_addr || hit_data;
    wire key_wr    = wr_do && hit_key && lane0;
    wire ctrl_wr   = wr_do && hit_ctrl && lane0;
    wire data_wr   = wr_do && hit_data && lane0;
    wire flash_wr  = data_wr && program_store_write_enable;
    wire xdata_go  = data_wr && !program_store_write_enable;
    wire sw_op     = flash_wr && (key_q == KEY_OPEN);
    wire sw_bad    = flash_wr && (key_q != KEY_OPEN);
    wire dbg_go    = dbg_valid && !op_busy && !wait_op_q && !wr_do;
    wire op_start  = sw_op || dbg_go;
    wire op_erase  = dbg_go ? dbg_erase : program_store_erase_enable;
    wire [FLASH_AW-1:0] op_addr = dbg_go ? dbg_addr : addr_q;
    wire [7:0]          op_data = dbg_go ? dbg_data : wdata_q[7:0];
    wire [TMR_W-1:0]    op_count = op_erase ? TMR_W'(ERASE_COUNT) : TMR_W'(PROG_COUNT);

    // ---------------------------------------------------------------
    // unlock key sequencer
    // ---------------------------------------------------------------
    always_comb begin
        key_d = key_q;
        case (key_q)
            KEY_LOCKED: begin
                if (key_wr) begin
                    key_d = (wdata_q[7:0] == KEY_FIRST) ? KEY_HALF : KEY_DEAD;
                end else if (sw_bad) begin
                    key_d = KEY_DEAD;
                end
            end
            KEY_HALF: begin
                if (key_wr) begin
                    key_d = (wdata_q[7:0] == KEY_SECOND) ? KEY_OPEN : KEY_DEAD;
                end else if (sw_bad) begin
                    key_d = KEY_DEAD;
                end
            end
            KEY_OPEN: begin
                if (key_wr) begin
                    key_d = KEY_DEAD;
                end else if (sw_op) begin
                    key_d = KEY_LOCKED;
                end
            end
            default: begin
                key_d = KEY_DEAD;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // flash write port and erase sweep
    // ---------------------------------------------------------------
    wire sweep_on  = erasing_q && !sweep_q[PAGE_AW];
    wire mem_we    = (op_start && !op_erase) || sweep_on;
    wire [FLASH_AW-1:0] page_base = {op_addr_q[FLASH_AW-1:PAGE_AW], {PAGE_AW{1'b0}}};
    wire [FLASH_AW-1:0] mem_waddr = sweep_on ? (page_base | FLASH_AW'(sweep_q[PAGE_AW-1:0])) : op_addr;
    wire [7:0]          mem_wdata = sweep_on ? ERASED_BYTE : op_data;

    fpe_array u_array (
        .aclk     (aclk),
        .we       (mem_we),
        .and_mode (!sweep_on),
        .waddr    (mem_waddr),
        .wdata    (mem_wdata),
        .raddr    (addr_q),
        .rdata    (flash_rdata)
    );

    fpe_timer u_timer (
        .aclk    (aclk),
        .aresetn (aresetn),
        .load    (op_start),
        .count   (op_count),
        .busy    (op_busy),
        .done    (op_done)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            erasing_q <= 1'b0;
            sweep_q   <= '0;
            op_addr_q <= '0;
        end else if (op_start) begin
            erasing_q <= op_erase;
            sweep_q   <= '0;
            op_addr_q <= op_addr;
        end else if (sweep_on) begin
            sweep_q   <= sweep_q + (PAGE_AW+1)'(1);
        end else if (op_done) begin
            erasing_q <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // key, control and address registers
    // ---------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            key_q  <= KEY_LOCKED;
            ctrl_q <= CTRL_RST;
            addr_q <= '0;
        end else begin
            key_q <= key_d;
            if (ctrl_wr) begin
                ctrl_q <= {wdata_q[CTRL_RT_BIT], 2'b00, wdata_q[CTRL_EE_BIT], wdata_q[CTRL_WE_BIT]};
            end
            if (wr_do && hit_addr) begin
                addr_q <= wdata_q[FLASH_AW-1:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // AXI write channels
    // ---------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
        end else begin
            if (aw_take) begin
                awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (w_take) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            aw_have_q <= (aw_have_q || aw_take) && !wr_do;
            w_have_q  <= (w_have_q || w_take) && !wr_do;
            awready_q <= !(aw_have_q || aw_take) || wr_do;
            wready_q  <= !(w_have_q || w_take) || wr_do;
        end
    end

    // response waits for the timed operation to end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            wait_op_q <= 1'b0;
        end else begin
            if (sw_op) begin
                wait_op_q <= 1'b1;
            end else if (wait_op_q && op_done) begin
                wait_op_q <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= RESP_OKAY;
            end else if (wr_do) begin
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q  <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // AXI read channel
    // ---------------------------------------------------------------
    assign araddr_w = {s_axi_araddr[7:2], 2'b00};
    wire ar_take    = s_axi_arvalid && arready_q;
    wire [31:0] stat_word = {29'h0, key_q, op_busy};
    wire [31:0] rd_word =
        (araddr_w == OFS_KEY)    ? 32'h0000_0000 :
        (araddr_w == OFS_CTRL)   ? {27'h0, ctrl_q} :
        (araddr_w == OFS_STATUS) ? stat_word :
        (araddr_w == OFS_ADDR)   ? {17'h0, addr_q} :
        (araddr_w == OFS_DATA)   ? {24'h0, flash_rdata} : 32'h0000_0000;
    wire rd_mapped  = (araddr_w == OFS_KEY) || (araddr_w == OFS_CTRL) || (araddr_w == OFS_STATUS)
                   || (araddr_w == OFS_ADDR) || (araddr_w == OFS_DATA);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= RESP_OKAY;
        end else begin
            if (ar_take) begin
                rvalid_q  <= 1'b1;
                rdata_q   <= rd_word;
                rresp_q   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
                arready_q <= 1'b0;
            end else if (rvalid_q && s_axi_rready) begin
                rvalid_q  <= 1'b0;
                arready_q <= 1'b1;
            end else if (!rvalid_q) begin
                arready_q <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // side outputs
    // ---------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stall_q   <= 1'b0;
            dbg_ack_q <= 1'b0;
            xwr_q     <= '0;
        end else begin
            stall_q     <= op_start || (op_busy && !op_done);
            dbg_ack_q   <= dbg_go;
            xwr_q.valid <= xdata_go;
            if (xdata_go) begin
                xwr_q.addr <= addr_q;
                xwr_q.data <= wdata_q[7:0];
            end
        end
    end

    assign s_axi_awready            = awready_q;
    assign s_axi_wready             = wready_q;
    assign s_axi_bvalid             = bvalid_q;
    assign s_axi_bresp              = bresp_q;
    assign s_axi_arready            = arready_q;
    assign s_axi_rvalid             = rvalid_q;
    assign s_axi_rdata              = rdata_q;
    assign s_axi_rresp              = rresp_q;
    assign dbg_ack                  = dbg_ack_q;
    assign core_stall               = stall_q;
    assign flash_read_timing_select = ctrl_q[CTRL_RT_BIT];
    assign xdata_wr                 = xwr_q;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // cycles since the running operation was started
    logic [TMR_W-1:0] op_age_q;

    always_ff @(posedge aclk) begin
        if (!aresetn || op_start) begin
            op_age_q <= '0;
        end else if (op_busy) begin
            op_age_q <= op_age_q + TMR_W'(1);
        end
    end

    key_first_a: assert property (key_wr && key_q == KEY_LOCKED && wdata_q[7:0] == KEY_FIRST
        |=> key_q == KEY_HALF) else $error("first key not taken");
    key_bad_a: assert property (key_wr && key_q == KEY_HALF && wdata_q[7:0] != KEY_SECOND
        |=> key_q == KEY_DEAD) else $error("bad second key accepted");
    lockout_hold_a: assert property (key_q == KEY_DEAD |=> key_q == KEY_DEAD)
        else $error("lockout left before reset");
    early_op_a: assert property (sw_bad |=> key_q == KEY_DEAD && !op_busy)
        else $error("early flash write did not lock out");
    relock_a: assert property (sw_op |=> key_q == KEY_LOCKED)
        else $error("key not relocked after operation");
    stall_run_a: assert property (op_start |=> stall_q [*2])
        else $error("execution not stalled");
    resp_hold_a: assert property (wait_op_q && op_busy |-> !bvalid_q)
        else $error("response before operation end");
    we_stable_a: assert property (!ctrl_wr |=> $stable(program_store_write_enable))
        else $error("write enable changed by hardware");
    redirect_a: assert property (xdata_go |=> xwr_q.valid && !op_busy)
        else $error("data move not sent to data memory");
    prog_time_a: assert property (op_busy && !erasing_q |-> op_age_q < TMR_W'(PROG_COUNT))
        else $error("program not timed");
    sweep_page_a: assert property (sweep_on
        |-> mem_waddr[FLASH_AW-1:PAGE_AW] == op_addr_q[FLASH_AW-1:PAGE_AW])
        else $error("erase left its page");

    prog_seen_c: cover property (sw_op && !program_store_erase_enable);
    erase_seen_c: cover property (sw_op && program_store_erase_enable);
    lockout_seen_c: cover property (key_q == KEY_HALF ##1 key_q == KEY_DEAD);
    dbg_seen_c: cover property (dbg_go);
endmodule

// File: fpe_core_model.sv
// Purpose: core-side model: data memory behind data moves, stall counter
// Assumes: xdata_wr valid is a one-cycle pulse
// Notes:   counts every cycle that execution is held off
`timescale 1ns/1ps
module fpe_core_model
    import fpe_pkg::*;
(
    input  wire logic                aclk,
    input  wire logic                core_stall,
    input  wire fpe_xwr_s            xdata_wr,
    input  wire logic [FLASH_AW-1:0] raddr,
    output logic [7:0]               rdata,
    output logic [31:0]              stall_cnt
);
    logic [7:0] dmem [0:(1<<FLASH_AW)-1];
    initial stall_cnt = 32'h0;
    always @(posedge aclk) begin
        if (core_stall) stall_cnt <= stall_cnt + 32'h1;
        if (xdata_wr.valid) dmem[xdata_wr.addr] <= xdata_wr.data;
    end
    assign rdata = dmem[raddr];
endmodule

// File: fpe_testbench.sv
// Purpose: self-checking bench of the flash program/erase controller
// Assumes: shortened program and erase counts
// Notes:   software side drives AXI4-Lite, debug side drives the strobe port
`timescale 1ns/1ps
module testbench;
    import fpe_pkg::*;
    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    localparam int PC = 4;
    localparam int EC = 600;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, dv, de;
    logic        awready, wready, bvalid, arready, rvalid, dack, stall, rts;
    logic [7:0]  awaddr, araddr, ddat, mrd, ev [3];
    logic [31:0] wdata, rdata, scnt, seed, s0, rv;
    logic [1:0]  bresp, rresp;
    logic [14:0] dadr;
    fpe_xwr_s    xw;
    logic [1:0]  exp_b [$];
    logic [33:0] exp_r [$];
    int          failures, check_count, cyc;
    fpe_ctrl #(.PROG_COUNT(PC), .ERASE_COUNT(EC)) uut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .dbg_valid(dv), .dbg_erase(de),
        .dbg_addr(dadr), .dbg_data(ddat), .dbg_ack(dack), .core_stall(stall),
        .flash_read_timing_select(rts), .xdata_wr(xw));
    fpe_core_model core (.aclk(aclk), .core_stall(stall), .xdata_wr(xw), .raddr(dadr),
        .rdata(mrd), .stall_cnt(scnt));
    always #5 aclk = ~aclk;
    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic cmp(input logic [33:0] e, input logic [33:0] g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("unexpected value at %0t: exp %h got %h", $time, e, g);
        end
    endtask
    task automatic chk_b(input logic [1:0] e, input logic [1:0] g);
        cmp(34'(e), 34'(g));
    endtask
    task automatic chk_r(input logic [33:0] e, input logic [33:0] g);
        cmp(e, g);
    endtask
    task automatic chk_s(input logic [31:0] e, input logic [31:0] g);
        cmp(34'(e), 34'(g));
    endtask
    task automatic test_done();
        $display("checks %0d, failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
        @(posedge aclk);
        exp_b.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
        @(posedge aclk);
        exp_r.push_back({r, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask
    // write and check the count of stalled cycles
    task automatic stw(input logic [31:0] d, input int n);
        s0 = scnt;
        wr(OFS_DATA, d);
        chk_s(32'h1, 32'(scnt - s0 >= n && scnt - s0 <= n + (n != 0)));
    endtask
    task automatic op(input logic [14:0] a, input logic [7:0] d, input int n);
        wr(OFS_KEY, 32'hA5);
        wr(OFS_ADDR, {17'h0, a});
        wr(OFS_KEY, 32'hF1);
        rd(OFS_STATUS, 32'h4);
        stw({24'h0, d}, n);
        rd(OFS_STATUS, 32'h0);
    endtask
    task automatic dbg(input logic e, input logic [14:0] a, input logic [7:0] d);
        @(posedge aclk);
        dv <= 1'b1;
        de <= e;
        dadr <= a;
        ddat <= d;
        do @(posedge aclk); while (dack !== 1'b1);
        dv <= 1'b0;
        do @(posedge aclk); while (stall !== 1'b0);
    endtask
    task automatic rst();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    always @(posedge aclk) begin
        if (bvalid && bready) chk_b(exp_b.pop_front(), bresp);
        if (rvalid && rready) chk_r(exp_r.pop_front(), {rresp, rdata});
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            test_done();
        end
    end
    // ---------------------------------------------------------------
    // sequence
    // ---------------------------------------------------------------
    initial begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, dv, de} = '0;
        {awaddr, araddr, wdata, dadr, ddat} = '0;
        failures = 0;
        check_count = 0;
        cyc = 0;
        seed = 32'h82D3;
        rst();
        rd(OFS_CTRL, 32'h0);
        rd(OFS_STATUS, 32'h0);
        dadr <= 15'h155;
        wr(OFS_ADDR, 32'h155);
        wr(OFS_DATA, 32'h5A);
        @(negedge aclk);
        chk_s(32'h5A, {24'h0, mrd});
        wr(OFS_CTRL, 32'h11);
        chk_s(32'h1, {31'h0, rts});
        for (int i = 0; i < 3; i++) begin
            seed = xs(seed);
            rv = seed;
            op(15'h1FF + 15'(i), rv[7:0], PC);
            seed = xs(seed);
            op(15'h1FF + 15'(i), seed[7:0], PC);
            ev[i] = rv[7:0] & seed[7:0];
            rd(OFS_DATA, {24'h0, ev[i]});
        end
        wr(OFS_CTRL, 32'h13);
        op(15'h0, 8'h00, EC);
        rd(OFS_CTRL, 32'h13);
        wr(OFS_ADDR, 32'h1FF);
        rd(OFS_DATA, 32'hFF);
        wr(OFS_ADDR, 32'h200);
        rd(OFS_DATA, {24'h0, ev[1]});
        wr(OFS_CTRL, 32'h11);
        stw(32'h0, 0);
        rd(OFS_STATUS, 32'h6);
        wr(OFS_KEY, 32'hA5);
        wr(OFS_KEY, 32'hF1);
        rd(OFS_STATUS, 32'h6);
        stw(32'h0, 0);
        rd(OFS_DATA, {24'h0, ev[1]});
        dbg(1'b0, 15'h300, 8'h3C);
        wr(OFS_ADDR, 32'h300);
        rd(OFS_DATA, 32'h3C);
        dbg(1'b1, 15'h2A0, 8'h00);
        rd(OFS_DATA, 32'hFF);
        rd(OFS_STATUS, 32'h6);
        rst();
        rd(OFS_STATUS, 32'h0);
        wr(OFS_KEY, 32'hF1);
        rd(OFS_STATUS, 32'h6);
        rst();
        wr(OFS_KEY, 32'hA5);
        rd(OFS_STATUS, 32'h2);
        wr(OFS_KEY, 32'h00);
        rd(OFS_STATUS, 32'h6);
        wr(8'h14, 32'h1, RESP_SLVERR);
        rd(8'h14, 32'h0, RESP_SLVERR);
        repeat (4) @(posedge aclk);
        test_done();
    end
endmodule
